//--- sadc_pkg.sv
// Constants, register map and carrier types of the converter sequencer
// ----------------------------------------------------------------
// Summary of operation
// - Produce an 8-bit result from one of four pin channels via the mux.
// - Each completed conversion writes the result and, on the same edge, flags or interrupts.
// - The selected channel pin is forced to act as a converter input.
// - Unselected shared pins stay under ordinary port control.
// - Latch or direction writes never change the selected pin's state.
// - Port read of the selected pin gives 0 if direction 0, else latch.
// - One conversion takes exactly sixteen converter clock cycles.
// - A control/status write starts conversion on the next converter edge.
// - Continuous mode refreshes the result after every conversion, read or not.
// - Continuous conversions run back to back until the mode bit clears.
// - Without interrupts, done flag sets per conversion, cleared by result read.
// - Channel codes 0-3 select pins; all ones turns off; reset loads ones.
// - With interrupt enabled, interrupt per conversion; done flag reads 0.
// - Pending interrupt clears on result read or control/status write.
// - Divide field gives bus clock /1, /2, /4, /8; top bit set gives /16.
// ----------------------------------------------------------------
package sadc_pkg;
    // Byte addresses on the register bus
    localparam logic [7:0] ADDR_CSR = 8'h3c;
    localparam logic [7:0] ADDR_RESULT = 8'h40;
    localparam logic [7:0] ADDR_CLKDIV = 8'h44;
    localparam logic [7:0] ADDR_PORT_DATA = 8'h48;
    localparam logic [7:0] ADDR_PORT_DIR = 8'h4c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h50;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h54;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h58;
    // Field positions
    localparam int CSR_DONE_BIT = 7;
    localparam int DIV_LSB = 5;
    localparam int IRQ_CONV_BIT = 0;
    localparam int IRQ_OVR_BIT = 1;
    // Channels and reset values
    localparam int NUM_CH = 4;
    localparam logic [4:0] CHAN_OFF = 5'h1f;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [1:0] IRQ_EN_RESET = 2'h1;
    // Conversion timing in converter clock ticks
    localparam logic [3:0] CONV_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_LAST = 4'h7;
    localparam logic [7:0] SAR_FIRST = 8'h80;

    // Control/status fields that software writes
    typedef struct packed {
        logic irq_enable;
        logic continuous;
        logic [4:0] channel;
    } sadc_ctrl_t;

    localparam sadc_ctrl_t CTRL_RESET = '{irq_enable: 1'b0, continuous: 1'b0, channel: CHAN_OFF};

    // Steering for the analog multiplexer and converter core
    typedef struct packed {
        logic power;
        logic enable;
        logic [1:0] sel;
    } sadc_mux_t;

    typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_CONV} sadc_state_t;
endpackage

//--- sadc_sequencer.sv
// Successive-approximation converter sequencer with APB registers and pin sharing
`timescale 1ns/100ps
module sadc_sequencer (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog multiplexer and converter core
    output sadc_pkg::sadc_mux_t mux,
    output logic [7:0] dac_code,
    output logic sample_phase,
    input wire logic comp_in,
    output logic conv_busy,
    // Shared port pins
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    // Interrupt
    output logic irq
);
    import sadc_pkg::*;

    sadc_ctrl_t ctrl;
    logic [2:0] div_field;
    logic [7:0] result;
    logic done_flag;
    logic unread;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [3:0] port_latch;
    logic [3:0] port_dir;
    logic [3:0] pin_q1;
    logic [3:0] pin_q2;
    logic [3:0] pin_q3;
    logic [3:0] pin_val;
    logic [3:0] port_read;
    sadc_state_t state;
    logic [3:0] div_cnt;
    logic [3:0] tick_cnt;
    logic [7:0] sar;
    logic [2:0] bit_idx;
    logic tick;
    logic start_evt;
    logic done_evt;
    logic chan_valid;
    logic setup;
    logic wr;
    logic rd;
    logic mapped;
    logic wr_csr;
    logic rd_result;
    logic [31:0] read_word;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    // Zero wait states: data is fetched in the setup cycle
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_csr = wr & (paddr == ADDR_CSR);
    assign rd_result = rd & (paddr == ADDR_RESULT);

    // Address decode and read data selection
    always_comb begin
        mapped = 1'b1;
        read_word = 32'h0;
        case (paddr)
            ADDR_CSR: read_word = {24'h0, done_flag & ~ctrl.irq_enable, ctrl};
            ADDR_RESULT: read_word = {24'h0, result};
            ADDR_CLKDIV: read_word = {24'h0, div_field, 5'h0};
            ADDR_PORT_DATA: read_word = {28'h0, port_read};
            ADDR_PORT_DIR: read_word = {28'h0, port_dir};
            ADDR_IRQ_STAT: read_word = {30'h0, irq_stat};
            ADDR_IRQ_CLR: read_word = 32'h0;
            ADDR_IRQ_EN: read_word = {30'h0, irq_en};
            default: mapped = 1'b0;
        endcase
    end

    // Read data is registered so it stands stable through the access phase
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata <= 32'h0;
        end else if (setup & ~pwrite) begin
            prdata <= read_word;
        end
    end

    // Control/status fields; the done bit position is read-only
    // channel off at reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl <= CTRL_RESET;
        end else if (wr_csr) begin
            ctrl <= pwdata[6:0];
        end
    end

    // Clock divide field and interrupt enables
    always_ff @(posedge mclk) begin
        if (reset) begin
            div_field <= DIV_RESET;
            irq_en <= IRQ_EN_RESET;
        end else begin
            if (wr & (paddr == ADDR_CLKDIV)) begin
                div_field <= pwdata[DIV_LSB +: 3];
            end
            if (wr & (paddr == ADDR_IRQ_EN)) begin
                irq_en <= pwdata[1:0];
            end
        end
    end

    // Port latch and direction; the selected pin ignores them at the pin
    // latch writes kept
    always_ff @(posedge mclk) begin
        if (reset) begin
            port_latch <= 4'h0;
            port_dir <= 4'h0;
        end else begin
            if (wr & (paddr == ADDR_PORT_DATA)) begin
                port_latch <= pwdata[3:0];
            end
            if (wr & (paddr == ADDR_PORT_DIR)) begin
                port_dir <= pwdata[3:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Shared pins
    // ----------------------------------------------------------------
    // Three-stage synchroniser; a change counts once stages two and three agree
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_q1 <= 4'h0;
            pin_q2 <= 4'h0;
            pin_q3 <= 4'h0;
            pin_val <= 4'h0;
        end else begin
            pin_q1 <= pin_in;
            pin_q2 <= pin_q1;
            pin_q3 <= pin_q2;
            pin_val <= (pin_q2 & pin_q3) | (pin_val & (pin_q2 ^ pin_q3));
        end
    end

    assign chan_valid = (ctrl.channel < 5'(NUM_CH));

    for (genvar i = 0; i < NUM_CH; i++) begin : g_pin
        logic sel;
        assign sel = chan_valid & (ctrl.channel[1:0] == 2'(i));
        assign pin_oe[i] = port_dir[i] & ~sel;
        assign pin_out[i] = port_latch[i];
        // selected pin reads latch or 0
        assign port_read[i] = sel ? (port_dir[i] & port_latch[i])
                                  : (port_dir[i] ? port_latch[i] : pin_val[i]);
    end

    assign mux = '{power: ctrl.channel != CHAN_OFF, enable: chan_valid,
                   sel: ctrl.channel[1:0]};

    // ----------------------------------------------------------------
    // Converter clock and sequencing
    // ----------------------------------------------------------------
    // divide ratio minus one
    function automatic logic [3:0] div_last(input logic [2:0] f);
        logic [3:0] r;
        r = 4'hf;
        if (!f[2]) begin
            case (f[1:0])
                2'h0: r = 4'h0;
                2'h1: r = 4'h1;
                2'h2: r = 4'h3;
                default: r = 4'h7;
            endcase
        end
        return r;
    endfunction

    // Free-running prescaler; >= keeps it sane if the ratio shrinks mid-count
    assign tick = (div_cnt >= div_last(div_field));

    always_ff @(posedge mclk) begin
        if (reset) begin
            div_cnt <= 4'h0;
        end else if (tick) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // start on first converter edge after a write
    assign start_evt = (state == ST_ARM) & tick & ~wr_csr;
    // tick fifteen after the start tick closes the conversion
    assign done_evt = (state == ST_CONV) & tick & (tick_cnt == CONV_LAST) & ~wr_csr;

    // Sequencer; a write mid-conversion abandons it without writing a result and restarts, or goes idle if the channel code is all ones
    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= ST_IDLE;
        end else if (wr_csr) begin
            state <= (pwdata[4:0] == CHAN_OFF) ? ST_IDLE : ST_ARM;
        end else begin
            case (state)
                ST_IDLE: state <= ST_IDLE;
                ST_ARM: begin
                    if (tick) begin
                        state <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (done_evt) begin
                        state <= ctrl.continuous ? ST_ARM : ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Tick number within the conversion; start tick is number zero
    always_ff @(posedge mclk) begin
        if (reset) begin
            tick_cnt <= 4'h0;
        end else if (start_evt) begin
            tick_cnt <= 4'h1;
        end else if ((state == ST_CONV) & tick) begin
            tick_cnt <= tick_cnt + 4'h1;
        end
    end

    // Ticks 8..15 resolve bits 7..0
    assign bit_idx = ~tick_cnt[2:0];

    // Successive approximation: first half samples, second half trials bits
    always_ff @(posedge mclk) begin
        if (reset) begin
            sar <= 8'h0;
        end else if (start_evt) begin
            sar <= 8'h0;
        end else if ((state == ST_CONV) & tick) begin
            if (tick_cnt == SAMPLE_LAST) begin
                sar <= SAR_FIRST;
            end else if (tick_cnt[3]) begin
                sar[bit_idx] <= comp_in;
                if (bit_idx != 3'h0) begin
                    sar[3'(bit_idx - 3'h1)] <= 1'b1;
                end
            end
        end
    end

    assign dac_code = sar;
    assign sample_phase = (state == ST_CONV) & ~tick_cnt[3];
    assign conv_busy = (state != ST_IDLE);

    // ----------------------------------------------------------------
    // Result, flag and interrupts
    // ----------------------------------------------------------------
    // result overwritten every conversion
    always_ff @(posedge mclk) begin
        if (reset) begin
            result <= 8'h0;
        end else if (done_evt) begin
            result <= {sar[7:1], comp_in};
        end
    end

    // done flag; a set in the clearing cycle wins
    always_ff @(posedge mclk) begin
        if (reset) begin
            done_flag <= 1'b0;
        end else if (done_evt & ~ctrl.irq_enable) begin
            done_flag <= 1'b1;
        end else if (rd_result) begin
            done_flag <= 1'b0;
        end
    end

    // Tracks whether the current result has been read, for overrun
    always_ff @(posedge mclk) begin
        if (reset) begin
            unread <= 1'b0;
        end else if (done_evt) begin
            unread <= 1'b1;
        end else if (rd_result) begin
            unread <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_stat[IRQ_CONV_BIT] <= 1'b0;
        end else if (done_evt & ctrl.irq_enable) begin
            irq_stat[IRQ_CONV_BIT] <= 1'b1;
        end else if (rd_result | wr_csr
                     | (wr & (paddr == ADDR_IRQ_CLR) & pwdata[IRQ_CONV_BIT])) begin
            irq_stat[IRQ_CONV_BIT] <= 1'b0;
        end
    end

    // Overrun: a result replaced before software read it
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_stat[IRQ_OVR_BIT] <= 1'b0;
        end else if (done_evt & unread) begin
            irq_stat[IRQ_OVR_BIT] <= 1'b1;
        end else if (wr & (paddr == ADDR_IRQ_CLR) & pwdata[IRQ_OVR_BIT]) begin
            irq_stat[IRQ_OVR_BIT] <= 1'b0;
        end
    end

    assign irq = |(irq_stat & irq_en);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [8:0] cyc_since;
    logic div_wr_seen;

    // Bus cycles since the start tick, and whether the ratio was touched
    always_ff @(posedge mclk) begin
        if (reset) begin
            cyc_since <= 9'h0;
            div_wr_seen <= 1'b0;
        end else if (start_evt) begin
            cyc_since <= 9'h0;
            div_wr_seen <= 1'b0;
        end else begin
            cyc_since <= cyc_since + 9'h1;
            if (wr & (paddr == ADDR_CLKDIV)) begin
                div_wr_seen <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_csr_start;
        wr_csr && (pwdata[4:0] != CHAN_OFF);
    endsequence

    sequence s_done_quiet;
        done_evt && !wr_csr;
    endsequence

    // Counter restarts the edge after the start tick, so the done tick reads one short
    a_conv_length: assert property (
        done_evt && !div_wr_seen |->
            cyc_since == 9'(15 * (int'(div_last(div_field)) + 1) - 1))
        else $error("conversion length is not sixteen converter ticks");
    // The slowest ratio still yields a tick within sixteen bus cycles of arming
    a_start_edge: assert property (
        s_csr_start |=> (state == ST_ARM) ##[0:15] (start_evt || wr_csr))
        else $error("conversion did not start after control write");
    a_flag_set: assert property (
        s_done_quiet ##0 !ctrl.irq_enable |=>
            done_flag ##0 (result[7:1] == $past(sar[7:1])))
        else $error("done flag not set at end of conversion");
    a_flag_masked: assert property (
        setup && !pwrite && (paddr == ADDR_CSR) && ctrl.irq_enable |=> !prdata[CSR_DONE_BIT])
        else $error("done flag visible while interrupts enabled");
    a_irq_pending: assert property (
        s_done_quiet ##0 ctrl.irq_enable ##0 irq_en[IRQ_CONV_BIT] |=> irq && !done_flag)
        else $error("conversion interrupt not raised");
    a_irq_clear: assert property (
        (rd_result || wr_csr) && !done_evt |=> !irq_stat[IRQ_CONV_BIT])
        else $error("pending interrupt not cleared");
    a_pin_override: assert property (
        chan_valid |-> !pin_oe[ctrl.channel[1:0]])
        else $error("selected pin is driven by port logic");
    a_port_read: assert property (
        setup && !pwrite && (paddr == ADDR_PORT_DATA) && chan_valid |=>
            prdata[$past(ctrl.channel[1:0])] ==
            ($past(port_dir[ctrl.channel[1:0]]) & $past(port_latch[ctrl.channel[1:0]])))
        else $error("selected pin read value wrong");
    a_single_idle: assert property (
        s_done_quiet ##0 !ctrl.continuous |=> (state == ST_IDLE) [*2])
        else $error("single conversion did not return to idle");
    a_cont_next: assert property (
        s_done_quiet ##0 ctrl.continuous |=> (state == ST_ARM) ##[0:16] start_evt)
        else $error("continuous conversion did not follow");
    a_off_idle: assert property (
        ctrl.channel == CHAN_OFF |-> state == ST_IDLE)
        else $error("converter active while powered off");
endmodule

//--- sadc_analog_model.sv
// Behavioural analog side: channel levels, sample-hold, comparator and pin wiring
`timescale 1ns/100ps
module sadc_analog_model (
    // Clock
    input wire logic mclk,
    // Converter steering from the sequencer
    input wire sadc_pkg::sadc_mux_t mux,
    input wire logic [7:0] dac_code,
    input wire logic sample_phase,
    output logic comp_in,
    // Channel levels as 8-bit codes, channel 0 in the low byte
    input wire logic [31:0] levels,
    // Shared pins
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] ext_level,
    output logic [3:0] pin_in
);
    import sadc_pkg::*;

    // ----------------------------------------------------------------
    // Sample and hold
    // ----------------------------------------------------------------
    logic [7:0] held = 8'h00;
    logic toggle = 1'b0;

    // one channel routed
    // Level is held only while sampling, so a late input change cannot skew the bits
    always_ff @(posedge mclk) begin
        toggle <= ~toggle;
        if (sample_phase && mux.enable) begin
            held <= levels[{mux.sel, 3'b000} +: 8];
        end
    end

    // No channel routed: comparator output wanders rather than holding a level
    assign comp_in = mux.enable ? (held >= dac_code) : toggle;

    // ----------------------------------------------------------------
    // Pin levels
    // ----------------------------------------------------------------
    // undriven pins take ext_level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

//--- tb_top.sv
// Self-checking bench for the converter sequencer over APB
`timescale 1ns/100ps
module tb_top;
    import sadc_pkg::*;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    sadc_mux_t mux;
    logic [7:0] dac_code;
    logic sample_phase;
    logic comp_in;
    logic conv_busy;
    logic [3:0] pin_in;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic irq;
    logic [3:0] ext_level = 4'ha;
    logic [31:0] levels = 32'hc35a01fe;
    logic [31:0] rd;
    logic err;
    int n;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [2:0] divs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    int ratio [6] = '{1, 2, 4, 8, 16, 16};

    sadc_sequencer i_sadc_sequencer (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mux(mux),
        .dac_code(dac_code), .sample_phase(sample_phase), .comp_in(comp_in),
        .conv_busy(conv_busy), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .irq(irq));

    sadc_analog_model i_sadc_analog_model (.mclk(mclk), .mux(mux), .dac_code(dac_code),
        .sample_phase(sample_phase), .comp_in(comp_in), .levels(levels),
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

    // Clock at 100 ns
    initial begin
        forever #50 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard, well above the fifteen hundred or so cycles the run needs
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            error_cnt++;
            $display("MISMATCH %0t timeout", $time);
            wrap_up();
        end
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
                              input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi, input string what);
        samples_checked++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check_word(rd, exp, what);
    endtask

    task automatic settle();
        repeat (5) @(posedge mclk);
    endtask

    // Counts edges from the starting write until busy is seen low
    task automatic wait_idle();
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (conv_busy !== 1'b0 && n < 2000);
        settle();
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        rd_chk(ADDR_CSR, 32'h1f, "csr reset");
        rd_chk(ADDR_CLKDIV, 32'h0, "div reset");
        rd_chk(ADDR_IRQ_EN, 32'h1, "irq en reset");
        check_word({28'h0, pin_oe}, 32'h0, "oe reset");
        check_word({31'h0, mux.power}, 32'h0, "power reset");
        $display("test reset done");

        for (int c = 0; c < 4; c++) begin
            wr(ADDR_CSR, c);
            wait_idle();
            check_range(n, 17, 18, "conv time");
            check_word({28'h0, mux}, {28'h0, 2'b11, c[1:0]}, "mux");
            rd_chk(ADDR_CSR, 32'h80 | c, "done set");
            rd_chk(ADDR_RESULT, {24'h0, levels[c*8 +: 8]}, "result");
            rd_chk(ADDR_CSR, c, "done clear");
        end
        $display("test channels done");

        foreach (divs[i]) begin
            wr(ADDR_CLKDIV, {24'h0, divs[i], 5'h0});
            wr(ADDR_CSR, 32'h2);
            wait_idle();
            check_range(n, 15 * ratio[i] + 2, 16 * ratio[i] + 2, "div time");
            rd_chk(ADDR_RESULT, 32'h5a, "div result");
        end
        wr(ADDR_CLKDIV, 32'h0);
        $display("test divider done");

        wr(ADDR_CSR, 32'h1);
        repeat (5) @(posedge mclk);
        wr(ADDR_CSR, 32'h2);
        wait_idle();
        check_range(n, 17, 18, "restart time");
        rd_chk(ADDR_RESULT, 32'h5a, "restart result");
        $display("test restart done");

        wr(ADDR_CSR, 32'h23);
        repeat (40) @(posedge mclk);
        levels[31:24] <= 8'h3c;
        repeat (40) @(posedge mclk);
        check_word({31'h0, conv_busy}, 32'h1, "still running");
        rd_chk(ADDR_RESULT, 32'h3c, "refreshed");
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        check_word(rd & 32'h2, 32'h2, "overrun");
        wr(ADDR_CSR, 32'h3);
        wait_idle();
        repeat (40) @(posedge mclk);
        check_word({31'h0, conv_busy}, 32'h0, "single idle");
        rd_chk(ADDR_RESULT, 32'h3c, "single result");
        wr(ADDR_CSR, 32'h1f);
        repeat (40) @(posedge mclk);
        check_word({30'h0, conv_busy, mux.power}, 32'h0, "off");
        $display("test continuous done");

        wr(ADDR_IRQ_CLR, 32'h3);
        wr(ADDR_IRQ_EN, 32'h0);
        wr(ADDR_CSR, 32'h40);
        wait_idle();
        check_word({31'h0, irq}, 32'h0, "masked");
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        check_word(rd & 32'h1, 32'h1, "sticky");
        rd_chk(ADDR_CSR, 32'h40, "done reads 0");
        wr(ADDR_IRQ_EN, 32'h1);
        settle();
        check_word({31'h0, irq}, 32'h1, "unmasked");
        wr(ADDR_IRQ_CLR, 32'h1);
        settle();
        check_word({31'h0, irq}, 32'h0, "cleared");
        wr(ADDR_CSR, 32'h40);
        wait_idle();
        check_word({31'h0, irq}, 32'h1, "raised");
        rd_chk(ADDR_RESULT, 32'hfe, "irq result");
        settle();
        check_word({31'h0, irq}, 32'h0, "read clears");
        wr(ADDR_CSR, 32'h40);
        wait_idle();
        check_word({31'h0, irq}, 32'h1, "raised again");
        wr(ADDR_CSR, 32'h1f);
        settle();
        check_word({31'h0, irq}, 32'h0, "write clears");
        $display("test interrupt done");

        wr(ADDR_PORT_DIR, 32'hf);
        wr(ADDR_PORT_DATA, 32'h7);
        settle();
        check_word({24'h0, pin_oe, pin_out}, 32'hf7, "port only");
        wr(ADDR_CSR, 32'h1);
        settle();
        check_word({28'h0, pin_oe}, 32'hd, "pin taken");
        wr(ADDR_PORT_DATA, 32'h5);
        wr(ADDR_PORT_DIR, 32'hf);
        settle();
        check_word({24'h0, pin_oe, pin_out}, 32'hd5, "pin kept");
        wr(ADDR_PORT_DATA, 32'h7);
        rd_chk(ADDR_PORT_DATA, 32'h7, "read dir 1");
        wr(ADDR_PORT_DIR, 32'hd);
        rd_chk(ADDR_PORT_DATA, 32'h5, "read dir 0");
        wr(ADDR_PORT_DIR, 32'h0);
        settle();
        rd_chk(ADDR_PORT_DATA, 32'h8, "inputs");
        $display("test pins done");

        wr(8'h00, 32'hff);
        check_word({31'h0, err}, 32'h1, "unmapped wr err");
        apb(1'b0, 8'h00, 32'h0);
        check_word({err, rd[30:0]}, 32'h80000000, "unmapped rd");
        $display("test unmapped done");
        wrap_up();
    end
endmodule
